// ---- hdl/erac_pkg.sv ----
package erac_pkg;

   // Register byte offsets (control and address are 64-bit, two 32-bit words each; status is one word)
   localparam logic [11:0] CTRL_LO_OFF      = 12'h008;
   localparam logic [11:0] CTRL_HI_OFF      = 12'h00c;
   localparam logic [11:0] STAT_OFF         = 12'h010;
   localparam logic [11:0] ADDR_LO_OFF      = 12'h018;
   localparam logic [11:0] ADDR_HI_OFF      = 12'h01c;

   // Address register field positions
   localparam int ADDR_SEC_BIT        = 63;
   localparam int ADDR_SECWRONG_BIT   = 62;
   localparam int ADDR_UNREL_BIT      = 61;
   localparam int ADDR_PA_MSB         = 55;

   // Control register field positions
   localparam int CTL_ED_BIT          = 0;
   localparam int CTL_IMP1_BIT        = 1;
   localparam int CTL_UI_BIT          = 2;
   localparam int CTL_FI_BIT          = 3;
   localparam int CTL_UE_BIT          = 4;
   localparam int CTL_WUI_BIT         = 5;
   localparam int CTL_WFI_BIT         = 6;
   localparam int CTL_WUE_BIT         = 7;
   localparam int CTL_CFI_BIT         = 8;
   localparam int CTL_CORRECTED_FAULT_IRQ_ENABLE_WR_BIT        = 9;
   localparam int CTL_DUI_BIT         = 10;
   localparam int CTL_DEFERRED_RECOVERY_IRQ_ENABLE_WR_BIT        = 11;

   // Status register bit positions (own layout)
   localparam int STAT_AV_BIT         = 0;

   // Reset values
   localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;

   // Feature support codes per control
   typedef enum logic [1:0]
   {
      ERAC_FEAT_NONE  = 2'b00,
      ERAC_FEAT_FIXED = 2'b01,
      ERAC_FEAT_CTRL  = 2'b10,
      ERAC_FEAT_SPLIT = 2'b11
   } erac_feat_t;

   // Error event from the node
   typedef struct packed
   {
      logic        valid;
      logic        is_write;
      logic        corrected;
      logic        deferred;
      logic        uncorrected;
      logic        ce_overflow;
      logic        has_addr;
      logic        sec_attr;
      logic        sec_wrong;
      logic        addr_unrel;
      logic [55:0] paddr;
   } erac_err_t;

   // Effective enables after layout decode
   typedef struct packed
   {
      logic detect;
      logic abort;
      logic fault_irq;
      logic recovery_irq;
   } erac_resp_t;

endpackage

// ---- hdl/erac_regs.sv ----
// Summary of operation
// R1 - A recorded error with an address loads that address into the address register
// R2 - Software writes to the address register are dropped while address-valid is set
// R3 - Address bit 63 holds security attribute, zero secure, one non-secure
// R4 - Address bit 62 flags a possibly wrong security attribute
// R5 - Address bit 61 flags a possibly incomplete or incorrect physical address
// R6 - Bits 55 to 0 hold address; unimplemented and bits 60 to 56 read zero
// R7 - Enables for unsupported features read zero and ignore writes
// R8 - Only the first record of a node has a working control register
// R9 - Control bits 63:32 and 1 accept zero writes; bits 31:12 read zero
// R10 - Combined bit 10 raises recovery interrupt on every deferred error
// R11 - Enabled interrupts fire even when a lower priority syndrome is discarded
// R12 - Combined bit 8 raises fault interrupt on corrected errors; with a counter, only on corrected errors that overflow it
// R13 - Combined bit 4 answers uncorrected non-deferrable errors with an abort
// R14 - Combined bit 3 raises fault interrupt for deferred and uncorrected errors
// R15 - Combined bit 2 raises recovery interrupt for uncorrected non-deferred errors
// R16 - Split layout puts write enables at 11,9,7,6,5 and read enables at 10,8,4,3,2
// R17 - Combined layout reserved bits 11, 9, 7 to 5 read zero
// R18 - With bit 0 clear no detection or correction is done on reads
// R19 - Detection enable clears to zero on cold reset
// R20 - Combined or split layout is chosen per control at elaboration
`timescale 1ns/10ps
`default_nettype none

module erac_regs #(
   parameter int                  PA_WIDTH    = 56,
   parameter bit                  FIRST_REC   = 1'b1,
   parameter bit                  HAS_CE_CNT  = 1'b0,
   parameter erac_pkg::erac_feat_t FEAT_ED    = erac_pkg::ERAC_FEAT_CTRL,
   parameter erac_pkg::erac_feat_t FEAT_UI    = erac_pkg::ERAC_FEAT_CTRL,
   parameter erac_pkg::erac_feat_t FEAT_FI    = erac_pkg::ERAC_FEAT_CTRL,
   parameter erac_pkg::erac_feat_t FEAT_UE    = erac_pkg::ERAC_FEAT_CTRL,
   parameter erac_pkg::erac_feat_t FEAT_CFI   = erac_pkg::ERAC_FEAT_CTRL,
   parameter erac_pkg::erac_feat_t FEAT_DUI   = erac_pkg::ERAC_FEAT_CTRL,
   parameter bit                  ADDR_FLAGS_RW = 1'b1,
   parameter logic [31:0]         IMP_HI_MASK = 32'h0000_0000
)(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   input  wire erac_pkg::erac_err_t err_in,
   input  wire logic                address_valid_flag,
   input  wire logic                txn_is_write,
   input  wire logic                txn_uncorr_nodefer,
   output logic                     detect_rd_en,
   output logic                     inband_abort,
   output logic                     fault_irq,
   output logic                     recovery_irq
);

   initial
   begin
      if (PA_WIDTH < 1 || PA_WIDTH > 56)
         $error("PA_WIDTH must be 1 to 56");
      if (FEAT_ED == erac_pkg::ERAC_FEAT_SPLIT || FEAT_ED == erac_pkg::ERAC_FEAT_NONE)
         $error("FEAT_ED must be fixed or controllable");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable bit masks derived from supported features

   function automatic logic [11:0] feat_mask(input erac_pkg::erac_feat_t f,
                                             input int rb, input int wb);
      logic [11:0] m;
      m = 12'h000;
      if (f == erac_pkg::ERAC_FEAT_CTRL || f == erac_pkg::ERAC_FEAT_SPLIT)
         m[rb] = 1'b1;
      if (f == erac_pkg::ERAC_FEAT_SPLIT)
         m[wb] = 1'b1;
      return m;
   endfunction

   // Enable for a given direction; fixed features are always on
   function automatic logic eff_en(input erac_pkg::erac_feat_t f, input logic [11:0] c,
                                   input int rb, input int wb, input logic wr);
      logic e;
      e = 1'b0;
      unique case (f)
         erac_pkg::ERAC_FEAT_NONE:  e = 1'b0;
         erac_pkg::ERAC_FEAT_FIXED: e = 1'b1;
         erac_pkg::ERAC_FEAT_CTRL:  e = c[rb];
         erac_pkg::ERAC_FEAT_SPLIT: e = wr ? c[wb] : c[rb];
      endcase
      return e;
   endfunction

   localparam logic [11:0] CTL_MASK = FIRST_REC ? (                 // R8
      feat_mask(FEAT_ED,  erac_pkg::CTL_ED_BIT,  erac_pkg::CTL_ED_BIT)  |   // R7
      feat_mask(FEAT_UI,  erac_pkg::CTL_UI_BIT,  erac_pkg::CTL_WUI_BIT) |   // R16 R20
      feat_mask(FEAT_FI,  erac_pkg::CTL_FI_BIT,  erac_pkg::CTL_WFI_BIT) |
      feat_mask(FEAT_UE,  erac_pkg::CTL_UE_BIT,  erac_pkg::CTL_WUE_BIT) |
      feat_mask(FEAT_CFI, erac_pkg::CTL_CFI_BIT, erac_pkg::CTL_CORRECTED_FAULT_IRQ_ENABLE_WR_BIT) |
      feat_mask(FEAT_DUI, erac_pkg::CTL_DUI_BIT, erac_pkg::CTL_DEFERRED_RECOVERY_IRQ_ENABLE_WR_BIT)) : 12'h000; // R17

   localparam logic [55:0] PA_MASK = 56'hff_ffff_ffff_ffff >> (56 - PA_WIDTH); // R6

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait state, unmapped reads zero and flag an error

   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;
   logic [11:0] ctl_q;
   logic [31:0] imp_hi_q;
   logic [63:0] addr_q;

   assign pready = 1'b1;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign mapped = (paddr == erac_pkg::CTRL_LO_OFF) || (paddr == erac_pkg::CTRL_HI_OFF) ||
                   (paddr == erac_pkg::STAT_OFF)    || (paddr == erac_pkg::ADDR_LO_OFF) ||
                   (paddr == erac_pkg::ADDR_HI_OFF);
   assign pslverr = psel & penable & ~mapped;

   // Byte-lane merge of a 32-bit write word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   // Merged write words; a function result cannot be part-selected directly
   logic [31:0] ctl_merged;
   logic [31:0] addr_hi_merged;

   assign ctl_merged     = merge({20'h00000, ctl_q}, pwdata, pstrb);
   assign addr_hi_merged = merge(addr_q[63:32], pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_q <= erac_pkg::CTRL_RESET[11:0];                        // R19
      else if (wr_acc && paddr == erac_pkg::CTRL_LO_OFF)
         ctl_q <= ctl_merged[11:0] & CTL_MASK;                               // R7 R9
   end

   // Upper controls hold only bits the build declares implemented
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         imp_hi_q <= erac_pkg::CTRL_RESET[63:32];
      else if (wr_acc && paddr == erac_pkg::CTRL_HI_OFF && FIRST_REC)
         imp_hi_q <= merge(imp_hi_q, pwdata, pstrb) & IMP_HI_MASK;   // R9
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address register: capture beats software write

   logic [63:0] addr_cap;
   logic        flag_wmask;

   assign flag_wmask = ADDR_FLAGS_RW;
   assign addr_cap = {err_in.sec_attr, err_in.sec_wrong, err_in.addr_unrel,   // R3 R4 R5
                      5'h00, err_in.paddr & PA_MASK};                          // R6

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         addr_q <= erac_pkg::ADDR_RESET;
      else if (err_in.valid && err_in.has_addr)
         addr_q <= addr_cap;                                                   // R1
      else if (wr_acc && !address_valid_flag)                                  // R2
      begin
         if (paddr == erac_pkg::ADDR_LO_OFF)
            addr_q[31:0] <= merge(addr_q[31:0], pwdata, pstrb);
         else if (paddr == erac_pkg::ADDR_HI_OFF)
         begin
            addr_q[55:32] <= addr_hi_merged[23:0] & PA_MASK[55:32];
            if (flag_wmask)
               addr_q[62:61] <= addr_hi_merged[30:29];                      // R4 R5
            addr_q[63]    <= addr_hi_merged[31];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            erac_pkg::CTRL_LO_OFF: prdata <= {20'h00000, ctl_q};          // R9 R17
            erac_pkg::CTRL_HI_OFF: prdata <= imp_hi_q;
            erac_pkg::STAT_OFF:    prdata <= {31'h0000_0000, address_valid_flag};
            erac_pkg::ADDR_LO_OFF: prdata <= addr_q[31:0] & PA_MASK[31:0];
            erac_pkg::ADDR_HI_OFF: prdata <= {addr_q[63:61], 5'h00,
                                              addr_q[55:32] & PA_MASK[55:32]}; // R6
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Responses; interrupts use the error's direction, the abort uses the transaction's direction

   logic wr_dir;
   logic en_ed;
   logic en_ui;
   logic en_fi;
   logic en_cfi;
   logic en_dui;
   logic ce_hit;

   assign wr_dir = err_in.is_write;
   assign en_ed  = FIRST_REC && eff_en(FEAT_ED, ctl_q, erac_pkg::CTL_ED_BIT,
                                       erac_pkg::CTL_ED_BIT, 1'b0);
   assign en_ui  = eff_en(FEAT_UI, ctl_q, erac_pkg::CTL_UI_BIT, erac_pkg::CTL_WUI_BIT, wr_dir);
   assign en_fi  = eff_en(FEAT_FI, ctl_q, erac_pkg::CTL_FI_BIT, erac_pkg::CTL_WFI_BIT, wr_dir);
   assign en_cfi = eff_en(FEAT_CFI, ctl_q, erac_pkg::CTL_CFI_BIT, erac_pkg::CTL_CORRECTED_FAULT_IRQ_ENABLE_WR_BIT,
                          wr_dir);
   assign en_dui = eff_en(FEAT_DUI, ctl_q, erac_pkg::CTL_DUI_BIT, erac_pkg::CTL_DEFERRED_RECOVERY_IRQ_ENABLE_WR_BIT,
                          wr_dir);
   assign ce_hit = err_in.corrected & (HAS_CE_CNT ? err_in.ce_overflow : 1'b1);  // R12

   assign detect_rd_en = en_ed;                                                // R18

   // Abort is combinational so it can join the transaction's own response
   assign inband_abort = en_ed & txn_uncorr_nodefer &
                         eff_en(FEAT_UE, ctl_q, erac_pkg::CTL_UE_BIT,
                                erac_pkg::CTL_WUE_BIT, txn_is_write);           // R13

   // Record priority is not consulted: discarded syndromes still interrupt
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_irq    <= 1'b0;
         recovery_irq <= 1'b0;
      end
      else
      begin
         fault_irq    <= err_in.valid &&                                       // R11
                         ((en_fi && (err_in.deferred || err_in.uncorrected)) || // R14
                          (en_cfi && ce_hit) ||                                  // R12
                          (FEAT_CFI == erac_pkg::ERAC_FEAT_NONE && en_fi && ce_hit));
         recovery_irq <= err_in.valid &&
                         ((en_dui && err_in.deferred) ||                        // R10
                          (en_ui && err_in.uncorrected && !err_in.deferred));   // R15
      end
   end

endmodule
`default_nettype wire

// ---- verif/erac_regs_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module erac_regs_checker (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire erac_pkg::erac_err_t err_in,
   input wire logic                txn_uncorr_nodefer,
   input wire logic                detect_rd_en,
   input wire logic                inband_abort,
   input wire logic                fault_irq,
   input wire logic                recovery_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic mapped;
   logic ctl_wr;
   logic rec_src;
   assign acc = psel && penable;
   assign mapped = paddr inside {12'h008, 12'h00c, 12'h010, 12'h018, 12'h01c};
   assign ctl_wr = acc && pwrite && paddr == 12'h008;
   assign rec_src = err_in.valid && (err_in.deferred || err_in.uncorrected);
   ////////////////////////////////////////////////////////////////
   property p_slverr; acc && !mapped |-> pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_mapped; acc && mapped |-> pready && !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_rec; recovery_irq |-> $past(rec_src); endproperty
   a_rec: assert property (p_rec) else $error("recovery irq without cause");
   property p_fault; fault_irq |-> $past(err_in.valid); endproperty
   a_fault: assert property (p_fault) else $error("fault irq without error");
   // Irq follows its error by exactly one cycle
   property p_quiet; !err_in.valid ##1 !err_in.valid |-> !fault_irq && !recovery_irq; endproperty
   a_quiet: assert property (p_quiet) else $error("irq outside its pulse");
   property p_abort; inband_abort |-> txn_uncorr_nodefer && detect_rd_en; endproperty
   a_abort: assert property (p_abort) else $error("abort without cause");
   property p_ed_on; $rose(detect_rd_en) |-> $past(ctl_wr && pwdata[0]); endproperty
   a_ed_on: assert property (p_ed_on) else $error("detect enabled without write");
   property p_ed_off; $fell(detect_rd_en) |-> $past(ctl_wr && !pwdata[0]); endproperty
   a_ed_off: assert property (p_ed_off) else $error("detect cleared without write");
   c_fault: cover property (fault_irq);
   c_rec: cover property (recovery_irq);
   c_abort: cover property (inband_abort);
endmodule
bind erac_regs erac_regs_checker i_erac_regs_checker (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .err_in, .txn_uncorr_nodefer,
   .detect_rd_en, .inband_abort, .fault_irq, .recovery_irq);
`default_nettype wire

// ---- verif/erac_req_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module erac_req_model (
   input  wire logic               pclk,
   output var erac_pkg::erac_err_t err_in,
   output var logic                txn_is_write,
   output var logic                txn_uncorr_nodefer
);
   initial
   begin
      err_in = '0;
      txn_is_write = 1'b0;
      txn_uncorr_nodefer = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // Fields scrambled after the pulse so no stale value looks valid
   task automatic fire(input erac_pkg::erac_err_t e);
      @(posedge pclk);
      err_in <= e;
      @(posedge pclk);
      err_in <= {1'b0, ~e[64:0]};
   endtask
   task automatic set_txn(input logic w, input logic u);
      @(posedge pclk);
      txn_is_write <= w;
      txn_uncorr_nodefer <= u;
   endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   logic                pclk = 1'b0;
   logic                presetn = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0;
   logic                av_flag = 1'b0;
   logic                pready, pslverr, detect_rd_en, inband_abort;
   logic                fault_irq, recovery_irq, txn_is_write, txn_uncorr_nodefer;
   logic [31:0]         prdata;
   erac_pkg::erac_err_t err_in;
   logic [32:0]         exp_q[$];
   int                  num_errors = 0;
   int                  check_count = 0;
   int                  cyc = 0;
   erac_regs i_erac_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .pready, .prdata, .pslverr, .err_in, .address_valid_flag(av_flag),
      .txn_is_write, .txn_uncorr_nodefer, .detect_rd_en, .inband_abort, .fault_irq,
      .recovery_irq);
   erac_req_model i_erac_req_model (.pclk, .err_in, .txn_is_write, .txn_uncorr_nodefer);
   always #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   // Read results and the hang limit are watched here
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         num_errors++;
         print_verdict();
      end
      if (psel && penable && !pwrite && pready === 1'b1)
         `CHK({pslverr, prdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 33'hx)
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      erac_pkg::erac_err_t e;
      logic [31:0]         c;
      logic [31:0]         d;
      void'($urandom(32'h41f9d800));
      repeat (4) @(posedge pclk);
      `CHK(detect_rd_en, 1'b0)
      presetn <= 1'b1;
      rd(erac_pkg::CTRL_LO_OFF, 32'h0);
      rd(erac_pkg::ADDR_LO_OFF, 32'h0);
      apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
      $display("test reset done");
      wr(erac_pkg::CTRL_LO_OFF, 32'hffff_ffff);
      rd(erac_pkg::CTRL_LO_OFF, 32'h0000_051d);
      wr(erac_pkg::CTRL_HI_OFF, 32'hffff_ffff);
      rd(erac_pkg::CTRL_HI_OFF, 32'h0);
      `CHK(detect_rd_en, 1'b1)
      $display("test control done");
      repeat (6)
      begin
         c = ($urandom & 32'h0000_051c) | 32'h1;
         wr(erac_pkg::CTRL_LO_OFF, c);
         for (int k = 0; k < 3; k++)
         begin
            e = '0;
            e.valid = 1'b1;
            e.corrected = (k == 0);
            e.deferred = (k == 1);
            e.uncorrected = (k == 2);
            i_erac_req_model.fire(e);
            #1;
            `CHK(fault_irq, (c[3] && k > 0) || (c[8] && k == 0))
            `CHK(recovery_irq, (c[2] && k == 2) || (c[10] && k == 1))
         end
      end
      $display("test interrupts done");
      for (int u = 0; u < 2; u++)
      begin
         wr(erac_pkg::CTRL_LO_OFF, {27'h0, u[0], 4'h1});
         i_erac_req_model.set_txn(1'($urandom), 1'b1);
         #1;
         `CHK(inband_abort, u[0])
      end
      i_erac_req_model.set_txn(1'b0, 1'b0);
      $display("test abort done");
      d = $urandom;
      e = '0;
      e.valid = 1'b1;
      e.corrected = 1'b1;
      e.has_addr = 1'b1;
      e.sec_attr = 1'b1;
      e.sec_wrong = 1'b1;
      e.addr_unrel = 1'b1;
      e.paddr = {24'($urandom), d};
      i_erac_req_model.fire(e);
      rd(erac_pkg::ADDR_LO_OFF, d);
      rd(erac_pkg::ADDR_HI_OFF, {8'he0, e.paddr[55:32]});
      av_flag <= 1'b1;
      wr(erac_pkg::ADDR_LO_OFF, ~d);
      rd(erac_pkg::ADDR_LO_OFF, d);
      rd(erac_pkg::STAT_OFF, 32'h1);
      av_flag <= 1'b0;
      wr(erac_pkg::ADDR_LO_OFF, ~d);
      wr(erac_pkg::ADDR_HI_OFF, 32'hff00_0000);
      rd(erac_pkg::ADDR_LO_OFF, ~d);
      rd(erac_pkg::ADDR_HI_OFF, 32'he000_0000);
      $display("test address done");
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(erac_pkg::CTRL_LO_OFF, 32'h0);
      $display("test second reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
